/* ofd_decoder.sv */
// Operand field decoder: operands, immediates, branch targets, suffixes, pixel mask
`default_nettype none
module ofd_decoder (
  input  wire logic                    REF_CLK,
  input  wire logic                    RSTN,
  input  wire logic                    IN_VALID,
  output logic                         IN_READY,
  input  wire logic [31:0]             INSTR_WORD,
  input  wire logic [31:0]             INSTR_ADDR,
  input  wire ofd_pkg::ofd_form_t      OPND_FORM,
  input  wire logic                    IMM_LOGICAL,
  input  wire logic [31:0]             FIRST_SOURCE_FIELD_REG_VAL,
  input  wire logic [31:0]             SECOND_SOURCE_FIELD_REG_VAL,
  input  wire ofd_pkg::ofd_br_t        BR_KIND,
  input  wire ofd_pkg::ofd_prec_t      PREC_SUFFIX,
  input  wire logic                    PREC_RESTRICTED,
  input  wire logic                    IS_FP_ACCESS,
  input  wire ofd_pkg::ofd_size_t      ACC_SIZE,
  input  wire logic                    INTVEC_REQ,
  input  wire logic                    PM_WR,
  input  wire logic [2:0]              PM_WR_INDEX,
  input  wire logic                    PM_WR_BIT,
  input  wire logic [2:0]              PM_RD_INDEX,
  input  wire logic                    IO_ACK,
  input  wire logic [31:0]             IO_RDATA,
  output logic                         OUT_VALID,
  output logic [4:0]                   FIRST_SOURCE_FIELD_IDX,
  output logic [4:0]                   SECOND_SOURCE_FIELD_IDX,
  output logic [4:0]                   DEST_IDX,
  output logic [31:0]                  FIRST_SOURCE_FIELD_OPERAND,
  output logic [31:0]                  EFF_ADDR,
  output logic                         BR_VALID,
  output logic [31:0]                  BR_TARGET,
  output logic                         SRC_IS_DOUBLE,
  output logic                         RES_IS_DOUBLE,
  output logic                         PREC_ILLEGAL,
  output logic [7:0]                   XFER_BITS,
  output logic                         SIZE_ILLEGAL,
  output logic [7:0]                   PIXEL_MASK_BITS,
  output logic                         PM_RD_BIT,
  output logic                         IO_RD,
  output logic [31:0]                  IO_ADDR,
  output logic                         VEC_VALID,
  output logic [31:0]                  VEC_DATA
);
  import ofd_pkg::*;

  // ***************************************************************
  // Field decode
  // ***************************************************************
  wire         accept    = IN_VALID && IN_READY;
  wire [15:0]  imm16     = INSTR_WORD[IMM16_W-1:0];
  wire [31:0]  imm_zext  = {16'h0000, imm16};
  wire [31:0]  imm_sext  = {{16{imm16[15]}}, imm16};
  wire [4:0]   first_source_field_fld  = INSTR_WORD[FIRST_SOURCE_FIELD_LSB +: REG_W];
  wire [31:0]  short_ext = {27'h0000000, first_source_field_fld};
  wire [25:0]  lbroff    = INSTR_WORD[LBR_W-1:0];
  wire [15:0]  sbroff    = {INSTR_WORD[SBR_HI_LSB +: SBR_HI_W], INSTR_WORD[SBR_LO_W-1:0]};
  wire [31:0]  lbr_ext   = {{4{lbroff[25]}}, lbroff, 2'b00};
  wire [31:0]  sbr_ext   = {{14{sbroff[15]}}, sbroff, 2'b00};
  wire [31:0]  br_off    = (BR_KIND == OFD_BR_SHORT) ? sbr_ext : lbr_ext;
  wire [31:0]  br_tgt    = INSTR_ADDR + INSN_STEP + br_off;
  wire [31:0]  first_source_field_val;
  wire [31:0]  addr_off;
  wire [31:0]  ea;
  wire         prec_bad;
  wire [7:0]   int_bits;
  wire [7:0]   fp_bits;
  wire [31:0]  vec_mask;

  // Immediate forms only in the immediate encodings; register-only never
  assign first_source_field_val = (OPND_FORM == OFD_FORM_IMM16)      ? (IMM_LOGICAL ? imm_zext : imm_sext) :
                    (OPND_FORM == OFD_FORM_SHORT_IMM)  ? short_ext :
                    FIRST_SOURCE_FIELD_REG_VAL;
  // 16-bit addresses always take the sign-extended constant; the short form stays zero-extended
  assign addr_off = (OPND_FORM == OFD_FORM_IMM16) ? imm_sext :
                    (OPND_FORM == OFD_FORM_SHORT_IMM) ? short_ext : FIRST_SOURCE_FIELD_REG_VAL;
  assign ea       = SECOND_SOURCE_FIELD_REG_VAL + addr_off;
  assign prec_bad = PREC_RESTRICTED && (PREC_SUFFIX == OFD_PREC_DOUBLE_TO_SINGLE);
  assign int_bits = (ACC_SIZE == OFD_SIZE_SMALL) ? BITS_8 :
                    (ACC_SIZE == OFD_SIZE_MID)   ? BITS_16 :
                    (ACC_SIZE == OFD_SIZE_LARGE) ? BITS_32 : 8'h00;
  assign fp_bits  = (ACC_SIZE == OFD_SIZE_SMALL) ? BITS_32 :
                    (ACC_SIZE == OFD_SIZE_MID)   ? BITS_64 :
                    (ACC_SIZE == OFD_SIZE_LARGE) ? BITS_128 : 8'h00;
  assign vec_mask = (XFER_BITS == BITS_8)  ? MASK_8 :
                    (XFER_BITS == BITS_16) ? MASK_16 : MASK_32;

  // ***************************************************************
  // Decoded output stage
  // ***************************************************************
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      OUT_VALID     <= 1'b0;
      FIRST_SOURCE_FIELD_IDX      <= 5'h00;
      SECOND_SOURCE_FIELD_IDX      <= 5'h00;
      DEST_IDX      <= 5'h00;
      FIRST_SOURCE_FIELD_OPERAND  <= 32'h00000000;
      EFF_ADDR      <= 32'h00000000;
      BR_VALID      <= 1'b0;
      BR_TARGET     <= 32'h00000000;
      SRC_IS_DOUBLE <= 1'b0;
      RES_IS_DOUBLE <= 1'b0;
      PREC_ILLEGAL  <= 1'b0;
      XFER_BITS     <= 8'h00;
      SIZE_ILLEGAL  <= 1'b0;
    end else begin
      OUT_VALID <= accept;
      if (accept) begin
        FIRST_SOURCE_FIELD_IDX      <= first_source_field_fld;
        SECOND_SOURCE_FIELD_IDX      <= INSTR_WORD[SECOND_SOURCE_FIELD_LSB +: REG_W];
        DEST_IDX      <= INSTR_WORD[DEST_LSB +: REG_W];
        FIRST_SOURCE_FIELD_OPERAND  <= first_source_field_val;
        EFF_ADDR      <= ea;
        BR_VALID      <= (BR_KIND == OFD_BR_LONG) || (BR_KIND == OFD_BR_SHORT);
        BR_TARGET     <= br_tgt;
        SRC_IS_DOUBLE <= PREC_SUFFIX[1];
        RES_IS_DOUBLE <= PREC_SUFFIX[0];
        PREC_ILLEGAL  <= prec_bad;
        XFER_BITS     <= IS_FP_ACCESS ? fp_bits : int_bits;
        SIZE_ILLEGAL  <= (ACC_SIZE == OFD_SIZE_BAD);
      end
    end
  end

  // ***************************************************************
  // Pixel mask
  // ***************************************************************
  assign PM_RD_BIT = PIXEL_MASK_BITS[PM_RD_INDEX];

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      PIXEL_MASK_BITS <= PM_RESET;
    end else if (PM_WR) begin
      PIXEL_MASK_BITS[PM_WR_INDEX] <= PM_WR_BIT;
    end
  end

  // ***************************************************************
  // Interrupt vector read from I/O port
  // ***************************************************************
  ofd_state_t state_reg;
  ofd_state_t state_next;
  wire        vec_start = accept && INTVEC_REQ;
  wire        vec_done  = (state_reg == OFD_ST_WAIT) && IO_ACK;

  assign IN_READY = (state_reg == OFD_ST_IDLE);
  assign IO_RD    = (state_reg == OFD_ST_WAIT);

  always_comb begin
    case (state_reg)
      OFD_ST_IDLE: state_next = vec_start ? OFD_ST_WAIT : OFD_ST_IDLE;
      OFD_ST_WAIT: state_next = IO_ACK ? OFD_ST_IDLE : OFD_ST_WAIT;
      default:     state_next = OFD_ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state_reg <= OFD_ST_IDLE;
      IO_ADDR   <= 32'h00000000;
      VEC_VALID <= 1'b0;
      VEC_DATA  <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      VEC_VALID <= vec_done;
      if (vec_start) begin
        IO_ADDR <= ea;
      end
      if (vec_done) begin
        VEC_DATA <= IO_RDATA & vec_mask;
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  property p_reg_fields;
    accept |=> FIRST_SOURCE_FIELD_IDX == $past(INSTR_WORD[15:11]) && SECOND_SOURCE_FIELD_IDX == $past(INSTR_WORD[25:21])
               && DEST_IDX == $past(INSTR_WORD[20:16]) && OUT_VALID;
  endproperty
  a_reg_fields: assert property (p_reg_fields) else $error("register field select wrong");

  property p_imm_ext;
    accept && OPND_FORM == OFD_FORM_IMM16 |=>
      FIRST_SOURCE_FIELD_OPERAND == ($past(IMM_LOGICAL) ? {16'h0000, $past(INSTR_WORD[15:0])}
                                          : {{16{$past(INSTR_WORD[15])}}, $past(INSTR_WORD[15:0])});
  endproperty
  a_imm_ext: assert property (p_imm_ext) else $error("immediate extension wrong");

  property p_reg_only;
    accept && OPND_FORM == OFD_FORM_REG_ONLY |=> FIRST_SOURCE_FIELD_OPERAND == $past(FIRST_SOURCE_FIELD_REG_VAL);
  endproperty
  a_reg_only: assert property (p_reg_only) else $error("register-only source used as constant");

  property p_short_imm;
    accept && OPND_FORM == OFD_FORM_SHORT_IMM |=> FIRST_SOURCE_FIELD_OPERAND[31:5] == 27'h0000000
                                                  && FIRST_SOURCE_FIELD_OPERAND[4:0] == $past(INSTR_WORD[15:11]);
  endproperty
  a_short_imm: assert property (p_short_imm) else $error("short immediate wrong");

  property p_addr;
    accept && OPND_FORM == OFD_FORM_IMM16 |=>
      EFF_ADDR == $past(SECOND_SOURCE_FIELD_REG_VAL) + {{16{$past(INSTR_WORD[15])}}, $past(INSTR_WORD[15:0])};
  endproperty
  a_addr: assert property (p_addr) else $error("address offset not sign-extended");

  property p_long_br;
    accept && BR_KIND == OFD_BR_LONG |=> BR_VALID &&
      BR_TARGET == $past(INSTR_ADDR) + 32'h00000004 + {{4{$past(INSTR_WORD[25])}}, $past(INSTR_WORD[25:0]), 2'b00};
  endproperty
  a_long_br: assert property (p_long_br) else $error("long branch target wrong");

  property p_short_br;
    accept && BR_KIND == OFD_BR_SHORT |=> BR_VALID && BR_TARGET == $past(INSTR_ADDR) + 32'h00000004 +
      {{14{$past(INSTR_WORD[20])}}, $past(INSTR_WORD[20:16]), $past(INSTR_WORD[10:0]), 2'b00};
  endproperty
  a_short_br: assert property (p_short_br) else $error("short branch target wrong");

  property p_br_none;
    accept && BR_KIND == OFD_BR_NONE |=> !BR_VALID;
  endproperty
  a_br_none: assert property (p_br_none) else $error("branch flagged without offset");

  property p_prec;
    accept |=> SRC_IS_DOUBLE == $past(PREC_SUFFIX[1]) && RES_IS_DOUBLE == $past(PREC_SUFFIX[0]);
  endproperty
  a_prec: assert property (p_prec) else $error("precision suffix decode wrong");

  property p_prec_bad;
    accept |=> PREC_ILLEGAL == ($past(PREC_RESTRICTED) && $past(PREC_SUFFIX) == OFD_PREC_DOUBLE_TO_SINGLE);
  endproperty
  a_prec_bad: assert property (p_prec_bad) else $error("restricted precision check wrong");

  property p_int_size;
    accept && !IS_FP_ACCESS && ACC_SIZE == OFD_SIZE_MID |=> XFER_BITS == 8'h10 && !SIZE_ILLEGAL;
  endproperty
  a_int_size: assert property (p_int_size) else $error("halfword size wrong");

  property p_fp_size;
    accept && IS_FP_ACCESS && ACC_SIZE == OFD_SIZE_LARGE |=> XFER_BITS == 8'h80;
  endproperty
  a_fp_size: assert property (p_fp_size) else $error("quad size wrong");

  property p_pm_write;
    PM_WR |=> PIXEL_MASK_BITS[$past(PM_WR_INDEX)] == $past(PM_WR_BIT);
  endproperty
  a_pm_write: assert property (p_pm_write) else $error("pixel mask bit write lost");

  sequence s_vec_req;
    accept && INTVEC_REQ;
  endsequence
  sequence s_vec_ack;
    IO_RD && IO_ACK;
  endsequence
  property p_vec_issue;
    s_vec_req |=> IO_RD && !IN_READY && IO_ADDR == $past(ea);
  endproperty
  a_vec_issue: assert property (p_vec_issue) else $error("vector read not issued");
  property p_vec_return;
    s_vec_ack |=> VEC_VALID && !IO_RD && VEC_DATA == ($past(IO_RDATA) & $past(vec_mask));
  endproperty
  a_vec_return: assert property (p_vec_return) else $error("vector data wrong");
  property p_out_pulse;
    !accept |=> !OUT_VALID;
  endproperty
  a_out_pulse: assert property (p_out_pulse) else $error("decode result flagged without accept");
  property p_decode_hold;
    !accept |=> $stable(FIRST_SOURCE_FIELD_OPERAND) && $stable(EFF_ADDR) && $stable(BR_TARGET) && $stable(XFER_BITS);
  endproperty
  a_decode_hold: assert property (p_decode_hold) else $error("decode outputs changed without accept");
  property p_int_byte;
    accept && !IS_FP_ACCESS && ACC_SIZE == OFD_SIZE_SMALL |=> XFER_BITS == 8'h08 && !SIZE_ILLEGAL;
  endproperty
  a_int_byte: assert property (p_int_byte) else $error("byte size wrong");
  property p_int_word;
    accept && !IS_FP_ACCESS && ACC_SIZE == OFD_SIZE_LARGE |=> XFER_BITS == 8'h20 && !SIZE_ILLEGAL;
  endproperty
  a_int_word: assert property (p_int_word) else $error("word size wrong");
  property p_fp_single;
    accept && IS_FP_ACCESS && ACC_SIZE == OFD_SIZE_SMALL |=> XFER_BITS == 8'h20;
  endproperty
  a_fp_single: assert property (p_fp_single) else $error("single load size wrong");
  property p_fp_double;
    accept && IS_FP_ACCESS && ACC_SIZE == OFD_SIZE_MID |=> XFER_BITS == 8'h40;
  endproperty
  a_fp_double: assert property (p_fp_double) else $error("double load size wrong");
  property p_size_bad;
    accept && ACC_SIZE == OFD_SIZE_BAD |=> SIZE_ILLEGAL && XFER_BITS == 8'h00;
  endproperty
  a_size_bad: assert property (p_size_bad) else $error("illegal size not flagged");
  property p_pm_hold;
    !PM_WR |=> PIXEL_MASK_BITS == $past(PIXEL_MASK_BITS);
  endproperty
  a_pm_hold: assert property (p_pm_hold) else $error("pixel mask changed without write");
  sequence s_vec_wait;
    IO_RD && !IO_ACK;
  endsequence
  property p_vec_hold;
    s_vec_wait |=> IO_RD && !IN_READY && $stable(IO_ADDR);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector read dropped before answer");
endmodule
`default_nettype wire

/* ofd_pkg.sv */
// Constants and types for the operand field decoder
`default_nettype none
package ofd_pkg;
  localparam int REG_W       = 5;
  localparam int SECOND_SOURCE_FIELD_LSB    = 21;
  localparam int DEST_LSB    = 16;
  localparam int FIRST_SOURCE_FIELD_LSB    = 11;
  localparam int IMM16_W     = 16;
  localparam int LBR_W       = 26;
  localparam int SBR_HI_LSB  = 16;
  localparam int SBR_HI_W    = 5;
  localparam int SBR_LO_W    = 11;
  localparam int BR_SHIFT    = 2;
  localparam logic [31:0] INSN_STEP = 32'h00000004;
  localparam int PM_W        = 8;
  localparam int PM_IDX_W    = 3;
  localparam logic [7:0] PM_RESET = 8'h00;
  localparam logic [7:0] BITS_8   = 8'h08;
  localparam logic [7:0] BITS_16  = 8'h10;
  localparam logic [7:0] BITS_32  = 8'h20;
  localparam logic [7:0] BITS_64  = 8'h40;
  localparam logic [7:0] BITS_128 = 8'h80;
  localparam logic [31:0] MASK_8  = 32'h000000FF;
  localparam logic [31:0] MASK_16 = 32'h0000FFFF;
  localparam logic [31:0] MASK_32 = 32'hFFFFFFFF;

  typedef enum logic [1:0] {
    OFD_FORM_REG       = 2'h0,
    OFD_FORM_IMM16     = 2'h1,
    OFD_FORM_REG_ONLY  = 2'h2,
    OFD_FORM_SHORT_IMM = 2'h3
  } ofd_form_t;

  typedef enum logic [1:0] {
    OFD_BR_NONE  = 2'h0,
    OFD_BR_LONG  = 2'h1,
    OFD_BR_SHORT = 2'h2
  } ofd_br_t;

  // Bit 1 is source double, bit 0 is result double
  typedef enum logic [1:0] {
    OFD_PREC_SINGLE_TO_SINGLE = 2'h0,
    OFD_PREC_SINGLE_TO_DOUBLE = 2'h1,
    OFD_PREC_DOUBLE_TO_SINGLE = 2'h2,
    OFD_PREC_DOUBLE_TO_DOUBLE = 2'h3
  } ofd_prec_t;

  // Integer: byte/half/word; float: single/double/quad
  typedef enum logic [1:0] {
    OFD_SIZE_SMALL  = 2'h0,
    OFD_SIZE_MID    = 2'h1,
    OFD_SIZE_LARGE  = 2'h2,
    OFD_SIZE_BAD    = 2'h3
  } ofd_size_t;

  typedef enum logic {
    OFD_ST_IDLE = 1'b0,
    OFD_ST_WAIT = 1'b1
  } ofd_state_t;
endpackage
`default_nettype wire

/* ofd_decoder_tb_top.sv */
// Self-checking testbench for the operand field decoder
`default_nettype none
module ofd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ofd_pkg::*;
  logic        ref_clk, rstn, in_valid, imm_logical, prec_restricted, is_fp_access, intvec_req;
  logic        pm_wr, pm_wr_bit, io_ack, in_ready, out_valid, br_valid, src_is_double, res_is_double;
  logic        prec_illegal, size_illegal, pm_rd_bit, io_rd, vec_valid;
  logic [31:0] instr_word, instr_addr, first_source_field_reg_val, second_source_field_reg_val, io_rdata;
  logic [31:0] first_source_field_operand, eff_addr, br_target, io_addr, vec_data;
  logic [4:0]  first_source_field_idx, second_source_field_idx, dest_idx;
  logic [7:0]  xfer_bits, pixel_mask_bits;
  logic [2:0]  pm_wr_index, pm_rd_index;
  ofd_form_t   opnd_form;
  ofd_br_t     br_kind;
  ofd_prec_t   prec_suffix;
  ofd_size_t   acc_size;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  ofd_decoder i_ofd_decoder (
    .REF_CLK(ref_clk), .RSTN(rstn), .IN_VALID(in_valid), .IN_READY(in_ready), .INSTR_WORD(instr_word),
    .INSTR_ADDR(instr_addr), .OPND_FORM(opnd_form), .IMM_LOGICAL(imm_logical), .FIRST_SOURCE_FIELD_REG_VAL(first_source_field_reg_val),
    .SECOND_SOURCE_FIELD_REG_VAL(second_source_field_reg_val), .BR_KIND(br_kind), .PREC_SUFFIX(prec_suffix), .PREC_RESTRICTED(prec_restricted),
    .IS_FP_ACCESS(is_fp_access), .ACC_SIZE(acc_size), .INTVEC_REQ(intvec_req), .PM_WR(pm_wr),
    .PM_WR_INDEX(pm_wr_index), .PM_WR_BIT(pm_wr_bit), .PM_RD_INDEX(pm_rd_index), .IO_ACK(io_ack),
    .IO_RDATA(io_rdata), .OUT_VALID(out_valid), .FIRST_SOURCE_FIELD_IDX(first_source_field_idx), .SECOND_SOURCE_FIELD_IDX(second_source_field_idx), .DEST_IDX(dest_idx),
    .FIRST_SOURCE_FIELD_OPERAND(first_source_field_operand), .EFF_ADDR(eff_addr), .BR_VALID(br_valid), .BR_TARGET(br_target),
    .SRC_IS_DOUBLE(src_is_double), .RES_IS_DOUBLE(res_is_double), .PREC_ILLEGAL(prec_illegal),
    .XFER_BITS(xfer_bits), .SIZE_ILLEGAL(size_illegal), .PIXEL_MASK_BITS(pixel_mask_bits),
    .PM_RD_BIT(pm_rd_bit), .IO_RD(io_rd), .IO_ADDR(io_addr), .VEC_VALID(vec_valid), .VEC_DATA(vec_data));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Caller stands at a rising edge; one accept, results checked after it
  task automatic issue(input logic [31:0] w, input ofd_form_t f, input logic lg);
    instr_word <= w;
    opnd_form <= f;
    imm_logical <= lg;
    in_valid <= 1'b1;
    @(posedge ref_clk);
    in_valid <= 1'b0;
    #1;
    chk(32'(out_valid), 32'h1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_forms();
    logic [31:0] w;
    logic [31:0] sx;
    logic [31:0] op;
    for (int k = 0; k < 2; k++) begin
      w = k ? 32'h0000_7FFF : 32'h07E4_C5A3;
      sx = {{16{w[15]}}, w[15:0]};
      for (int i = 0; i < 5; i++) begin
        @(posedge ref_clk);
        first_source_field_reg_val <= 32'h1357_9BDF;
        second_source_field_reg_val <= 32'h8000_0040;
        issue(w, i == 0 ? OFD_FORM_REG : i < 3 ? OFD_FORM_IMM16 : i == 3 ? OFD_FORM_REG_ONLY : OFD_FORM_SHORT_IMM,
              i == 1);
        op = (i == 0 || i == 3) ? 32'h1357_9BDF : i == 1 ? {16'h0000, w[15:0]} : i == 2 ? sx : {27'h0, w[15:11]};
        chk(32'(first_source_field_idx), 32'(w[15:11]));
        chk(32'(second_source_field_idx), 32'(w[25:21]));
        chk(32'(dest_idx), 32'(w[20:16]));
        chk(first_source_field_operand, op);
        chk(eff_addr, 32'h8000_0040 + ((i == 1 || i == 2) ? sx : op));
      end
    end
    $display("test forms done");
  endtask

  task automatic t_branch();
    logic [31:0] ws [5] = '{32'h0200_0000, 32'h01FF_FFFF, 32'h0010_0000, 32'h000F_07FF, 32'h0123_4567};
    logic [15:0] so;
    logic [31:0] off;
    for (int i = 0; i < 5; i++) begin
      so = {ws[i][20:16], ws[i][10:0]};
      off = i < 2 ? {{6{ws[i][25]}}, ws[i][25:0]} : {{16{so[15]}}, so};
      @(posedge ref_clk);
      br_kind <= i < 2 ? OFD_BR_LONG : i < 4 ? OFD_BR_SHORT : OFD_BR_NONE;
      instr_addr <= 32'h8000_0100;
      issue(ws[i], OFD_FORM_REG, 1'b0);
      chk(32'(br_valid), 32'(i < 4));
      if (i < 4) begin
        chk(br_target, 32'h8000_0104 + (off << 2));
      end
    end
    $display("test branch done");
  endtask

  // Back-to-back accepts, one suffix per cycle
  task automatic t_prec();
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      prec_suffix <= ofd_prec_t'(i[1:0]);
      prec_restricted <= i[2];
      in_valid <= i < 8;
      #1;
      if (i > 0) begin
        chk(32'(out_valid), 32'h1);
        chk(32'({src_is_double, res_is_double}), 32'(i - 1) & 32'h3);
        chk(32'(prec_illegal), 32'((i - 1) == 6));
      end
    end
    $display("test precision done");
  endtask

  task automatic t_size();
    logic [7:0] tbl [8] = '{BITS_8, BITS_16, BITS_32, 8'h00, BITS_32, BITS_64, BITS_128, 8'h00};
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      acc_size <= ofd_size_t'(i[1:0]);
      is_fp_access <= i[2];
      issue(32'h0000_0000, OFD_FORM_REG, 1'b0);
      chk(32'(xfer_bits), 32'(tbl[i]));
      chk(32'(size_illegal), 32'(i[1:0] == 2'h3));
    end
    $display("test size done");
  endtask

  task automatic t_pmask();
    logic [7:0] pat = 8'hA5;
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      pm_wr <= i < 8;
      pm_wr_index <= 3'(i);
      pm_wr_bit <= pat[i[2:0]];
    end
    #1;
    chk(32'(pixel_mask_bits), 32'h0000_00A5);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      pm_rd_index <= 3'(i);
      #1;
      chk(32'(pm_rd_bit), 32'(pat[i[2:0]]));
    end
    $display("test pixel mask done");
  endtask

  // Slow answer, an offer held while refused, a stray strobe afterwards
  task automatic t_vec(input ofd_size_t sz, input logic [31:0] mask);
    @(posedge ref_clk);
    intvec_req <= 1'b1;
    acc_size <= sz;
    is_fp_access <= 1'b0;
    second_source_field_reg_val <= 32'h0000_2000;
    issue(32'h0000_FFF0, OFD_FORM_IMM16, 1'b0);
    chk(32'(io_rd), 32'h1);
    chk(32'(in_ready), 32'h0);
    chk(io_addr, 32'h0000_1FF0);
    @(posedge ref_clk);
    intvec_req <= 1'b0;
    in_valid <= 1'b1;
    @(posedge ref_clk);
    io_ack <= 1'b1;
    io_rdata <= 32'hCAFE_F00D;
    #1;
    chk(32'(out_valid), 32'h0);
    @(posedge ref_clk);
    io_ack <= 1'b0;
    io_rdata <= 32'h3501_0FF2;
    #1;
    chk(32'(vec_valid), 32'h1);
    chk(vec_data, 32'hCAFE_F00D & mask);
    chk(32'(in_ready), 32'h1);
    chk(32'(out_valid), 32'h0);
    @(posedge ref_clk);
    in_valid <= 1'b0;
    io_ack <= 1'b1;
    #1;
    chk(32'(out_valid), 32'h1);
    @(posedge ref_clk);
    io_ack <= 1'b0;
    #1;
    chk(32'(vec_valid), 32'h0);
    $display("test vector read done");
  endtask

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    rstn <= 1'b0;
    in_valid <= 1'b0;
    instr_word <= 32'h0;
    instr_addr <= 32'h0;
    opnd_form <= OFD_FORM_REG;
    imm_logical <= 1'b0;
    first_source_field_reg_val <= 32'h0;
    second_source_field_reg_val <= 32'h0;
    br_kind <= OFD_BR_NONE;
    prec_suffix <= OFD_PREC_SINGLE_TO_SINGLE;
    prec_restricted <= 1'b0;
    is_fp_access <= 1'b0;
    acc_size <= OFD_SIZE_SMALL;
    intvec_req <= 1'b0;
    pm_wr <= 1'b0;
    pm_wr_index <= 3'h0;
    pm_wr_bit <= 1'b0;
    pm_rd_index <= 3'h0;
    io_ack <= 1'b0;
    io_rdata <= 32'h0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk(32'(in_ready), 32'h1);
    chk(32'(io_rd), 32'h0);
    chk(32'(pixel_mask_bits), 32'(PM_RESET));
    t_forms();
    t_branch();
    t_prec();
    t_size();
    t_pmask();
    t_vec(OFD_SIZE_SMALL, MASK_8);
    t_vec(OFD_SIZE_MID, MASK_16);
    t_vec(OFD_SIZE_LARGE, MASK_32);
    close_out();
  end
endmodule
`default_nettype wire
